// ### logic/madsp_pkg.sv
// shared constants of the multiply-accumulate element
package madsp_pkg;
    // ======================================================================
    // datapath widths
    localparam int OP_W = 9;
    localparam int PROD_W = 2 * OP_W;
    localparam int ACC_W = 24;
    localparam int LANES = 4;

    // ======================================================================
    // register port
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_CFG = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_CLKSEL = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h2;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_EN = 4'h3;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_CLR = 4'h4;
    localparam logic [ADDR_W-1:0] ADDR_RESULT_LO = 4'h5;

    // ======================================================================
    // configuration fields
    localparam int CFG_MODE_LSB = 0;
    localparam int CFG_IN_BYP = 2;
    localparam int CFG_PIPE_BYP = 3;
    localparam int CFG_OUT_BYP = 4;
    localparam int CFG_W = 5;
    localparam logic [CFG_W-1:0] CFG_RESET = 5'h00;

    localparam logic [1:0] MODE_MAC = 2'h0;
    localparam logic [1:0] MODE_DUAL = 2'h1;
    localparam logic [1:0] MODE_QUAD = 2'h2;

    localparam int SEL_IN_LSB = 0;
    localparam int SEL_PIPE_LSB = 2;
    localparam int SEL_OUT_LSB = 4;
    localparam int SEL_W = 6;
    localparam logic [SEL_W-1:0] CLKSEL_RESET = 6'h00;

    // ======================================================================
    // event bits
    localparam int EVT_OVF = 0;
    localparam int EVT_INIT = 1;
    localparam int EVT_W = 2;
    localparam logic [EVT_W-1:0] EVT_RESET = 2'h0;
endpackage : madsp_pkg

// ### logic/madsp_stage.sv
// one bypassable register stage of the element
`timescale 1ns/1ps
module madsp_stage #(
    parameter int W = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clear,
    input wire logic load,
    input wire logic bypass,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] dataQ;

    // routing reset acts on any edge so a stopped source clock cannot hold stale data
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dataQ <= '0;
        end else if (clear) begin
            dataQ <= '0;
        end else if (load) begin
            dataQ <= d;
        end
    end

    assign q = bypass ? d : dataQ;
endmodule : madsp_stage

// ### logic/madsp_top.sv
// multiply-accumulate element with dual and quad product modes
`timescale 1ns/1ps
module madsp_top
    import madsp_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    // fabric operands and controls
    input wire logic [OP_W-1:0] a0,
    input wire logic [OP_W-1:0] b0,
    input wire logic [OP_W-1:0] a1,
    input wire logic [OP_W-1:0] b1,
    input wire logic [OP_W-1:0] a2,
    input wire logic [OP_W-1:0] b2,
    input wire logic [OP_W-1:0] a3,
    input wire logic [OP_W-1:0] b3,
    input wire logic subFirst,
    input wire logic subSecond,
    input wire logic accLoad,
    input wire logic [ACC_W-1:0] accInit,
    input wire logic stageCe,
    input wire logic stageRst,
    input wire logic clockSourceZero,
    input wire logic clockSourceOne,
    input wire logic clockSourceTwo,
    input wire logic clockSourceThree,
    output logic [ACC_W-1:0] result,
    output logic overflow,
    // register port
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [DATA_W-1:0] regRdData,
    output logic irq
);
    // ======================================================================
    // registers
    logic [CFG_W-1:0] cfgQ;
    logic [SEL_W-1:0] clkSelQ;
    logic [EVT_W-1:0] statusQ;
    logic [EVT_W-1:0] irqEnQ;
    logic [DATA_W-1:0] rdDataQ;
    logic [DATA_W-1:0] rdDataD;
    logic [1:0] mode;
    logic isMac;
    logic inBypass;
    logic pipeBypass;
    logic outBypass;
    logic clrWr;

    assign mode = cfgQ[CFG_MODE_LSB +: 2];
    assign isMac = (mode == MODE_MAC);
    assign inBypass = cfgQ[CFG_IN_BYP];
    assign pipeBypass = cfgQ[CFG_PIPE_BYP];
    // accumulate mode has no output bypass
    assign outBypass = cfgQ[CFG_OUT_BYP] && !isMac;
    assign clrWr = regWr && (regAddr == ADDR_IRQ_CLR);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfgQ <= CFG_RESET;
        end else if (regWr && regAddr == ADDR_CFG) begin
            cfgQ <= regWrData[CFG_W-1:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clkSelQ <= CLKSEL_RESET;
        end else if (regWr && regAddr == ADDR_CLKSEL) begin
            clkSelQ <= regWrData[SEL_W-1:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irqEnQ <= EVT_RESET;
        end else if (regWr && regAddr == ADDR_IRQ_EN) begin
            irqEnQ <= regWrData[EVT_W-1:0];
        end
    end

    // ======================================================================
    // clock source selection
    logic [3:0] srcMeta;
    logic [3:0] srcSync;
    logic [3:0] srcPrev;
    logic [3:0] srcRise;
    logic inEn;
    logic pipeEn;
    logic outEn;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            srcMeta <= 4'h0;
            srcSync <= 4'h0;
            srcPrev <= 4'h0;
        end else begin
            srcMeta <= {clockSourceThree, clockSourceTwo, clockSourceOne, clockSourceZero};
            srcSync <= srcMeta;
            srcPrev <= srcSync;
        end
    end

    // sources are sampled, so each must stay below half the system clock
    assign srcRise = srcSync & ~srcPrev;
    assign inEn = srcRise[clkSelQ[SEL_IN_LSB +: 2]] && stageCe;
    assign pipeEn = srcRise[clkSelQ[SEL_PIPE_LSB +: 2]] && stageCe;
    assign outEn = srcRise[clkSelQ[SEL_OUT_LSB +: 2]] && stageCe;

    // ======================================================================
    // input, multiplier and pipeline lanes
    logic [2*OP_W-1:0] opRaw [LANES];
    logic [2*OP_W-1:0] opReg [LANES];
    logic signed [PROD_W-1:0] prodRaw [LANES];
    logic signed [PROD_W-1:0] prod [LANES];

    assign opRaw[0] = {a0, b0};
    assign opRaw[1] = {a1, b1};
    assign opRaw[2] = {a2, b2};
    assign opRaw[3] = {a3, b3};

    for (genvar g = 0; g < LANES; g++) begin : gLane
        madsp_stage #(.W(2 * OP_W)) uIn (
            .clk(clk),
            .rst_n(rst_n),
            .clear(stageRst),
            .load(inEn),
            .bypass(inBypass),
            .d(opRaw[g]),
            .q(opReg[g])
        );
        assign prodRaw[g] = $signed(opReg[g][2*OP_W-1:OP_W]) * $signed(opReg[g][OP_W-1:0]);
        madsp_stage #(.W(PROD_W)) uPipe (
            .clk(clk),
            .rst_n(rst_n),
            .clear(stageRst),
            .load(pipeEn),
            .bypass(pipeBypass),
            .d(prodRaw[g]),
            .q(prod[g])
        );
    end

    // ======================================================================
    // adders
    logic signed [PROD_W:0] pairFirst;
    logic signed [PROD_W:0] pairSecond;
    logic signed [PROD_W+1:0] quadSum;
    logic signed [ACC_W-1:0] comboRes;

    // select high means the second product is subtracted
    assign pairFirst = subFirst ? prod[0] - prod[1] : prod[0] + prod[1];
    assign pairSecond = subSecond ? prod[2] - prod[3] : prod[2] + prod[3];
    assign quadSum = pairFirst + pairSecond;
    assign comboRes = (mode == MODE_QUAD) ? ACC_W'(quadSum) : ACC_W'(pairFirst);

    // ======================================================================
    // accumulator and output register
    logic signed [ACC_W-1:0] resultQ;
    logic signed [ACC_W-1:0] resultD;
    logic signed [ACC_W-1:0] prodExt;
    logic signed [ACC_W-1:0] accSum;
    logic ovfNow;
    logic ovfQ;
    logic ovfD;

    assign prodExt = ACC_W'(prod[0]);
    assign accSum = resultQ + prodExt;
    // two's complement overflow: like signs in, other sign out
    assign ovfNow = (resultQ[ACC_W-1] == prodExt[ACC_W-1]) && (accSum[ACC_W-1] != resultQ[ACC_W-1]);

    always_comb begin
        resultD = resultQ;
        ovfD = ovfQ;
        if (isMac) begin
            if (accLoad) begin
                resultD = accInit;
                ovfD = 1'b0;
            end else begin
                resultD = accSum;
                ovfD = ovfQ || ovfNow;
            end
        end else begin
            resultD = comboRes;
            ovfD = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            resultQ <= '0;
        end else if (stageRst) begin
            resultQ <= '0;
        end else if (outEn) begin
            resultQ <= resultD;
        end
    end

    // flag moves only with the output register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ovfQ <= 1'b0;
        end else if (stageRst) begin
            ovfQ <= 1'b0;
        end else if (outEn) begin
            ovfQ <= ovfD;
        end
    end

    assign result = outBypass ? comboRes : resultQ;
    assign overflow = ovfQ;

    // ======================================================================
    // events, status and interrupt
    logic [EVT_W-1:0] evtSet;

    assign evtSet[EVT_OVF] = outEn && !stageRst && ovfD && !ovfQ;
    assign evtSet[EVT_INIT] = outEn && !stageRst && isMac && accLoad;

    // a set in the clearing cycle survives
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            statusQ <= EVT_RESET;
        end else begin
            statusQ <= (statusQ & ~(clrWr ? regWrData[EVT_W-1:0] : EVT_RESET)) | evtSet;
        end
    end

    assign irq = |(statusQ & irqEnQ);

    // ======================================================================
    // read path
    always_comb begin
        rdDataD = '0;
        if (regRd) begin
            case (regAddr)
                ADDR_CFG: rdDataD = DATA_W'(cfgQ);
                ADDR_CLKSEL: rdDataD = DATA_W'(clkSelQ);
                ADDR_STATUS: rdDataD = DATA_W'(statusQ);
                ADDR_IRQ_EN: rdDataD = DATA_W'(irqEnQ);
                ADDR_RESULT_LO: rdDataD = resultQ[DATA_W-1:0];
                default: rdDataD = '0;
            endcase
        end
    end

    // answer stands for the one cycle after the strobe only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdDataQ <= '0;
        end else begin
            rdDataQ <= rdDataD;
        end
    end

    assign regRdData = rdDataQ;

    // ======================================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // widened copies keep the checks free of the adders' own widths
    logic signed [ACC_W-1:0] prodWide [LANES];

    for (genvar c = 0; c < LANES; c++) begin : gWide
        assign prodWide[c] = ACC_W'(prod[c]);
    end

    sequence macStep;
        isMac && outEn && !stageRst && !accLoad;
    endsequence

    sequence macInit;
        isMac && outEn && !stageRst && accLoad;
    endsequence

    accum_step_a: assert property (macStep ##0 (regWr == 1'b0) |=>
        resultQ == ACC_W'($past(resultQ) + $past(prodExt)))
        else $error("accumulator did not add the product");

    out_hold_a: assert property (isMac && !outEn && !stageRst && !regWr |=>
        $stable(resultQ) && result == resultQ)
        else $error("accumulator changed without its clock");

    in_bypass_a: assert property (inBypass |-> opReg[0] == opRaw[0])
        else $error("input bypass not honoured");

    acc_init_a: assert property (macInit ##0 (regWr == 1'b0) |=>
        resultQ == $past(accInit) && !ovfQ)
        else $error("accumulator not loaded with initial value");

    ovf_sync_a: assert property ($changed(ovfQ) |-> $past(outEn) || $past(stageRst))
        else $error("overflow moved off the output edge");

    dual_sum_a: assert property (mode == MODE_DUAL && outBypass |->
        result == (subFirst ? prodWide[0] - prodWide[1] : prodWide[0] + prodWide[1]))
        else $error("dual mode result wrong");

    quad_sum_a: assert property (mode == MODE_QUAD && outBypass |->
        result == (subFirst ? prodWide[0] - prodWide[1] : prodWide[0] + prodWide[1])
            + (subSecond ? prodWide[2] - prodWide[3] : prodWide[2] + prodWide[3]))
        else $error("quad mode result wrong");

    src_select_a: assert property (!inEn && !stageRst && !inBypass && !regWr |=>
        $stable(opReg[1]))
        else $error("input stage moved without its clock source");

    ovf_clear_a: assert property (stageRst |=> !ovfQ && resultQ == '0)
        else $error("routing reset did not clear the result");

    sequence ovfRaise;
        evtSet[EVT_OVF] && irqEnQ[EVT_OVF] && !regWr;
    endsequence

    // a clear or enable write in the window may legally drop irq
    irq_level_a: assert property (ovfRaise ##1 !regWr |-> irq [*2])
        else $error("overflow interrupt not raised");

    ce_gate_a: assert property (!stageCe && !stageRst |=>
        $stable(resultQ) && $stable(ovfQ))
        else $error("result moved while clock enable was low");

    out_reg_a: assert property (!isMac && !outBypass && outEn && !stageRst |=>
        resultQ == $past(comboRes))
        else $error("registered result did not capture the adder output");
endmodule : madsp_top

// ### sim/madsp_fabric.sv
// fabric-side model that pulses one of the four clock sources
`timescale 1ns/1ps
module madsp_fabric
    import madsp_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic fireReq,
    input wire logic [1:0] fireSrc,
    output logic [3:0] srcLines,
    output logic fireDone
);
    // ======================================================================
    // pulse sequencer
    logic [2:0] pulseCnt_q;
    logic [1:0] srcSel_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pulseCnt_q <= 3'h0;
            srcSel_q <= 2'h0;
        end else if (pulseCnt_q != 3'h0) begin
            pulseCnt_q <= pulseCnt_q + 3'h1;
        end else if (fireReq) begin
            pulseCnt_q <= 3'h1;
            srcSel_q <= fireSrc;
        end
    end

    // high two cycles, low at least six: well below clk/2 so the syncs never miss an edge
    assign srcLines = (pulseCnt_q == 3'h1 || pulseCnt_q == 3'h2) ? (4'h1 << srcSel_q) : 4'h0;
    assign fireDone = (pulseCnt_q == 3'h7);
endmodule : madsp_fabric

// ### sim/madsp_top_tb.sv
// self-checking bench of the multiply-accumulate element
`timescale 1ns/1ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin num_errors++; \
    $display("ERROR %0t: got %h expected %h", $time, got, exp); end end
module madsp_top_tb
    import madsp_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [OP_W-1:0] opA [LANES];
    logic [OP_W-1:0] opB [LANES];
    logic subFirst, subSecond, accLoad, stageCe, stageRst, regWr, regRd, irq, overflow;
    logic [ACC_W-1:0] accInit, result;
    logic [ADDR_W-1:0] regAddr;
    logic [DATA_W-1:0] regWrData, regRdData, expRd;
    logic [3:0] srcLines;
    logic [1:0] fireSrc, stat;
    logic fireReq, fireDone, en, ovf;
    logic sampleNow = 1'b0;
    logic rdPend = 1'b0;
    logic [ACC_W+1:0] expRes;
    logic signed [ACC_W-1:0] acc, p0, p1, p2, p3;
    logic [DATA_W-1:0] rdQ [$];
    logic [ACC_W+1:0] resQ [$];
    int num_errors = 0;
    int checks = 0;
    integer seed = 32'hca1c334c;

    always #25 clk = ~clk;

    madsp_fabric u_madsp_fabric (.clk(clk), .rst_n(rst_n), .fireReq(fireReq),
        .fireSrc(fireSrc), .srcLines(srcLines), .fireDone(fireDone));

    madsp_top u_madsp_top (.clk(clk), .rst_n(rst_n), .a0(opA[0]), .b0(opB[0]),
        .a1(opA[1]), .b1(opB[1]), .a2(opA[2]), .b2(opB[2]), .a3(opA[3]), .b3(opB[3]),
        .subFirst(subFirst), .subSecond(subSecond), .accLoad(accLoad), .accInit(accInit),
        .stageCe(stageCe), .stageRst(stageRst), .clockSourceZero(srcLines[0]),
        .clockSourceOne(srcLines[1]), .clockSourceTwo(srcLines[2]),
        .clockSourceThree(srcLines[3]), .result(result), .overflow(overflow),
        .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData(regRdData), .irq(irq));

    // ======================================================================
    // output watcher
    always @(posedge clk) begin
        rdPend <= regRd;
        if (rdPend) begin
            expRd = rdQ.pop_front();
            `CHK(regRdData, expRd)
        end
        if (sampleNow) begin
            expRes = resQ.pop_front();
            `CHK(({irq, overflow, result}), expRes)
        end
    end

    // ======================================================================
    // drivers and reference
    task automatic test_done();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : test_done

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        rdQ.push_back(e);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
    endtask : rd

    task automatic fire(input logic [1:0] s);
        int n;
        @(posedge clk);
        fireSrc <= s;
        fireReq <= 1'b1;
        @(posedge clk);
        fireReq <= 1'b0;
        n = 0;
        while (fireDone !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        if (n >= 20) begin
            num_errors++;
            $display("ERROR %0t: source pulse never finished", $time);
            test_done();
        end
        @(posedge clk);
    endtask : fire

    task automatic expectRes(input logic [ACC_W-1:0] r, input logic o);
        resQ.push_back({|(stat & {2{en}}), o, r});
        @(posedge clk);
        sampleNow <= 1'b1;
        @(posedge clk);
        sampleNow <= 1'b0;
    endtask : expectRes

    task automatic load(input logic [ACC_W-1:0] v);
        accInit <= v;
        accLoad <= 1'b1;
        fire(2'h0);
        accLoad <= 1'b0;
        acc = v;
        ovf = 1'b0;
        stat[EVT_INIT] = 1'b1;
    endtask : load

    task automatic macStep();
        logic signed [ACC_W-1:0] s;
        p0 = $signed(opA[0]) * $signed(opB[0]);
        s = acc + p0;
        if (p0[ACC_W-1] == acc[ACC_W-1] && s[ACC_W-1] != acc[ACC_W-1]) begin
            stat[EVT_OVF] = stat[EVT_OVF] | ~ovf;
            ovf = 1'b1;
        end
        acc = s;
    endtask : macStep

    task automatic randOps();
        for (int i = 0; i < LANES; i++) begin
            opA[i] <= OP_W'($random(seed));
            opB[i] <= OP_W'($random(seed));
        end
    endtask : randOps

    // ======================================================================
    // scenarios
    initial begin
        {subFirst, subSecond, accLoad, stageRst, regWr, regRd, fireReq} = '0;
        {accInit, regAddr, regWrData, fireSrc} = '0;
        stageCe = 1'b1;
        for (int i = 0; i < LANES; i++) begin
            opA[i] = '0;
            opB[i] = '0;
        end
        {acc, ovf, stat, en} = '0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        rd(ADDR_CFG, 8'h00);
        rd(ADDR_CLKSEL, 8'h00);
        rd(4'hf, 8'h00);
        wr(ADDR_STATUS, 8'hff);
        rd(ADDR_STATUS, 8'h00);
        expectRes(24'h0, 1'b0);
        // output bypass bit set: must be ignored in accumulate mode
        wr(ADDR_CFG, 8'h1c);
        load(ACC_W'($signed(16'($random(seed)))));
        expectRes(acc, ovf);
        rd(ADDR_STATUS, {6'h0, stat});
        repeat (6) begin
            opA[0] <= OP_W'($random(seed));
            opB[0] <= OP_W'($random(seed));
            expectRes(acc, ovf);
            macStep();
            fire(2'h0);
            expectRes(acc, ovf);
        end
        rd(ADDR_RESULT_LO, acc[7:0]);
        en = 1'b1;
        wr(ADDR_IRQ_EN, 8'h03);
        rd(ADDR_IRQ_EN, 8'h03);
        load(24'h7fffff);
        opA[0] <= 9'h001;
        opB[0] <= 9'h001;
        @(posedge clk);
        macStep();
        fire(2'h0);
        expectRes(acc, ovf);
        expectRes(acc, ovf);
        rd(ADDR_STATUS, {6'h0, stat});
        wr(ADDR_IRQ_CLR, 8'h03);
        stat = 2'h0;
        rd(ADDR_STATUS, 8'h00);
        expectRes(acc, ovf);
        stageCe <= 1'b0;
        fire(2'h0);
        expectRes(acc, ovf);
        stageCe <= 1'b1;
        load(24'h0);
        expectRes(acc, ovf);
        wr(ADDR_IRQ_CLR, 8'h02);
        stat = 2'h0;
        for (int s = 0; s < 4; s++) begin
            wr(ADDR_CLKSEL, DATA_W'(s << SEL_OUT_LSB));
            opA[0] <= OP_W'($random(seed));
            opB[0] <= OP_W'($random(seed));
            fire(2'(s + 1));
            expectRes(acc, ovf);
            macStep();
            fire(2'(s));
            expectRes(acc, ovf);
        end
        stageRst <= 1'b1;
        @(posedge clk);
        stageRst <= 1'b0;
        acc = '0;
        ovf = 1'b0;
        expectRes(24'h0, 1'b0);
        wr(ADDR_CLKSEL, 8'h00);
        for (int m = 1; m <= 2; m++) begin
            for (int b = 0; b < 2; b++) begin
                wr(ADDR_CFG, DATA_W'(b * 8'h1c + m));
                for (int k = 0; k < 4; k++) begin
                    subFirst <= k[0];
                    subSecond <= k[1];
                    randOps();
                    @(posedge clk);
                    p0 = $signed(opA[0]) * $signed(opB[0]);
                    p1 = $signed(opA[1]) * $signed(opB[1]);
                    p2 = $signed(opA[2]) * $signed(opB[2]);
                    p3 = $signed(opA[3]) * $signed(opB[3]);
                    p0 = k[0] ? p0 - p1 : p0 + p1;
                    p2 = k[1] ? p2 - p3 : p2 + p3;
                    if (b == 0)
                        repeat (3) fire(2'h0);
                    expectRes((m == 2) ? p0 + p2 : p0, 1'b0);
                end
            end
        end
        test_done();
    end
endmodule : madsp_top_tb
